// ---- design/gpmux_pkg.sv ----
// Constants, field layout and mode type for the eight-pin group multiplexer.
//
// Notes on behaviour
// R01: Eight multipurpose pins: group A is pins 0 to 3, group B 4 to 7.
// R02: Bits 0 to 6 of pin_group_config at offset 0x7B select pin function and direction.
// R03: Direction applies to a whole group of four pins; no per-pin direction.
// R04: Output groups drive bits 16 to 19 (A) and 20 to 23 (B).
// R05: Input groups show levels in bits 24 to 27 (A), 28 to 31 (B).
// R06: Bit 0 clear: monitor SPI; pins 3 to 7 are CS, SCK, MOSI, MISO, trigger.
// R07: After reset the monitor SPI main function is selected, pins 0 to 2 high impedance.
// R08: Patterns xx11001, xx00001, xx01001, xx10001 set GPIO group directions.
// R09: Patterns 11xx111 and 00xx111 select delta-sigma inputs with modulator clock out or in.
// R10: Only listed delta-sigma patterns are valid; software must not write others.
// R11: Monitor SPI main and GPIO functions exclude each other.
// R12: Input pin levels pass a two-stage synchronizer before they are read.
package gpmux_pkg;

  // ----------------------------------------------------------------------------
  // Register map and field positions
  // ----------------------------------------------------------------------------
  localparam logic [6:0] CFG_ADDR       = 7'h7b;
  localparam int         SEL_LSB        = 0;
  localparam int         SEL_W          = 7;
  localparam int         GENERAL_OUTPUT_LSB   = 16;
  localparam int         GENERAL_INPUT_A_LSB  = 24;
  localparam int         GENERAL_INPUT_B_LSB  = 28;
  localparam logic [6:0] SEL_RESET      = 7'h00;
  localparam logic [7:0] GENERAL_OUTPUT_RESET = 8'h00;

  // ----------------------------------------------------------------------------
  // Pin assignment in monitor mode
  // ----------------------------------------------------------------------------
  localparam int         PIN_MON_CS     = 3;
  localparam int         PIN_MON_SCK    = 4;
  localparam int         PIN_MON_MOSI   = 5;
  localparam int         PIN_MON_MISO   = 6;
  localparam int         PIN_MON_TRIG   = 7;
  localparam logic [7:0] MON_OE         = 8'h38;

  // ----------------------------------------------------------------------------
  // Modulator clock divider: system cycles per half period of the driven clock
  // ----------------------------------------------------------------------------
  localparam logic [3:0] DS_HALF_CYCLES = 4'h2;

  typedef enum logic [2:0] {
    GPMUX_MODE_MON,
    GPMUX_MODE_GPIO,
    GPMUX_MODE_DS_OUT,
    GPMUX_MODE_DS_IN,
    GPMUX_MODE_OFF
  } gpmux_mode_t;

endpackage

// ---- design/gpmux_pin_mux.sv ----
// Pin multiplexer for two groups of four multipurpose pins with its configuration register.
`timescale 1ns/1ps
module gpmux_pin_mux import gpmux_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        mod_clk_in,
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  input  wire logic        mon_cs_n,
  input  wire logic        mon_sck,
  input  wire logic        mon_mosi,
  output logic             mon_miso,
  output logic             monitor_trigger,
  output logic             mod_clk_out,
  output logic             mod_clk_oe,
  output logic      [7:0]  ds_bits,
  output logic             ds_sample,
  output logic             cfg_invalid,
  output logic             mode_monitor
);

  // ----------------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------------
  logic [6:0]  sel;
  logic [7:0]  general_output;
  logic        cfg_hit;

  assign cfg_hit = (reg_addr == CFG_ADDR);

  always_ff @(posedge clk) begin
    if (rst) begin
      sel            <= SEL_RESET; // R07
      general_output <= GENERAL_OUTPUT_RESET;
    end else if (ce && reg_wr && cfg_hit) begin
      sel            <= reg_wdata[SEL_LSB +: SEL_W]; // R02
      general_output <= reg_wdata[GENERAL_OUTPUT_LSB +: 8];
    end
  end

  // ----------------------------------------------------------------------------
  // Input synchronizer
  // ----------------------------------------------------------------------------
  logic [7:0]  pin_meta;
  logic [7:0]  pin_sync;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else if (ce) begin
      pin_meta <= pin_in;   // R12
      pin_sync <= pin_meta; // R12
    end
  end

  // ----------------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------------
  gpmux_mode_t mode;
  logic        a_out;
  logic        b_out;

  // An unlisted pattern parks every pin as an input rather than guessing a mix.
  always_comb begin
    mode = GPMUX_MODE_OFF;
    if (!sel[0]) begin
      mode = GPMUX_MODE_MON; // R06 R11
    end else if (sel[2:0] == 3'b001) begin
      mode = GPMUX_MODE_GPIO; // R08 R11
    end else if (sel[2:0] == 3'b111 && sel[6:5] == 2'b11) begin
      mode = GPMUX_MODE_DS_OUT; // R09
    end else if (sel[2:0] == 3'b111 && sel[6:5] == 2'b00) begin
      mode = GPMUX_MODE_DS_IN; // R09
    end
  end

  assign a_out        = (mode == GPMUX_MODE_GPIO) && sel[3]; // R08
  assign b_out        = (mode == GPMUX_MODE_GPIO) && sel[4]; // R08
  assign cfg_invalid  = (sel[2:0] == 3'b111) && (sel[6:5] == 2'b01 || sel[6:5] == 2'b10); // R10
  assign mode_monitor = (mode == GPMUX_MODE_MON);

  // ----------------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_oe  <= MON_OE; // R07
      pin_out <= 8'h00;
    end else if (ce) begin
      pin_out <= 8'h00;
      unique case (mode)
        GPMUX_MODE_MON: begin
          pin_oe                <= MON_OE; // R06
          pin_out[PIN_MON_CS]   <= mon_cs_n;
          pin_out[PIN_MON_SCK]  <= mon_sck;
          pin_out[PIN_MON_MOSI] <= mon_mosi;
        end
        GPMUX_MODE_GPIO: begin
          pin_oe  <= {{4{b_out}}, {4{a_out}}}; // R01 R03
          pin_out <= general_output; // R04
        end
        GPMUX_MODE_DS_OUT,
        GPMUX_MODE_DS_IN,
        GPMUX_MODE_OFF: begin
          pin_oe <= 8'h00; // R09 R10
        end
      endcase
    end
  end

  assign mon_miso        = mode_monitor & pin_sync[PIN_MON_MISO]; // R11
  assign monitor_trigger = mode_monitor & pin_sync[PIN_MON_TRIG];

  // ----------------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------------
  logic [3:0]  general_input_a;
  logic [3:0]  general_input_b;

  assign general_input_a = (mode == GPMUX_MODE_GPIO && !a_out) ? pin_sync[3:0] : 4'h0; // R05
  assign general_input_b = (mode == GPMUX_MODE_GPIO && !b_out) ? pin_sync[7:4] : 4'h0; // R05

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd && cfg_hit) begin
        reg_rdata <= {general_input_b, general_input_a, general_output, 9'h000, sel};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Modulator clock driven out
  // ----------------------------------------------------------------------------
  logic [3:0]  div_cnt;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt     <= 4'h0;
      mod_clk_out <= 1'b0;
      mod_clk_oe  <= 1'b0;
      ds_sample   <= 1'b0;
    end else if (ce) begin
      ds_sample  <= 1'b0;
      mod_clk_oe <= (mode == GPMUX_MODE_DS_OUT); // R09
      if (mode != GPMUX_MODE_DS_OUT) begin
        div_cnt     <= 4'h0;
        mod_clk_out <= 1'b0;
      end else if (div_cnt == DS_HALF_CYCLES - 4'h1) begin
        div_cnt     <= 4'h0;
        mod_clk_out <= ~mod_clk_out;
        ds_sample   <= ~mod_clk_out; // R09
      end else begin
        div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Modulator clock taken in: capture on the modulator's own clock
  // ----------------------------------------------------------------------------
  logic        ds_in_flag;
  logic        lk_en_meta;
  logic        lk_en;
  logic        lk_rst_meta;
  logic        lk_rst;
  logic [7:0]  lk_bits;
  logic [7:0]  lb_meta;
  logic [7:0]  lb_sync;

  always_ff @(posedge clk) begin
    if (rst) begin
      ds_in_flag <= 1'b0;
    end else if (ce) begin
      ds_in_flag <= (mode == GPMUX_MODE_DS_IN);
    end
  end

  always_ff @(posedge mod_clk_in) begin
    lk_rst_meta <= rst;
    lk_rst      <= lk_rst_meta;
    lk_en_meta  <= ds_in_flag;
    lk_en       <= lk_en_meta;
  end

  // The modulators launch on this clock, so the pins are captured here without resync.
  always_ff @(posedge mod_clk_in) begin
    if (lk_rst) begin
      lk_bits <= 8'h00;
    end else if (lk_en) begin
      lk_bits <= pin_in; // R09
    end
  end

  // Each bit is its own bitstream, so per-bit skew of one cycle is harmless.
  always_ff @(posedge clk) begin
    if (rst) begin
      lb_meta <= 8'h00;
      lb_sync <= 8'h00;
    end else if (ce) begin
      lb_meta <= lk_bits;
      lb_sync <= lb_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ds_bits <= 8'h00;
    end else if (ce) begin
      if (mode == GPMUX_MODE_DS_OUT && div_cnt == DS_HALF_CYCLES - 4'h1 && !mod_clk_out) begin
        ds_bits <= pin_sync; // R09
      end else if (mode == GPMUX_MODE_DS_IN) begin
        ds_bits <= lb_sync; // R09
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_default: assert property ($fell(rst) |-> sel == SEL_RESET && pin_oe == MON_OE) // R07
    else $error("reset did not select the monitor pin function");

  a_cfg_write: assert property (ce && reg_wr && cfg_hit |=> sel == $past(reg_wdata[6:0])) // R02
    else $error("select field did not take the written value");

  a_group_dir: assert property ((pin_oe[3:0] == 4'h0 || pin_oe[3:0] == 4'hf || pin_oe == MON_OE) // R03
                                && (pin_oe[7:4] == 4'h0 || pin_oe[7:4] == 4'hf || pin_oe == MON_OE))
    else $error("pins of one group point in different directions");

  a_output_drive_a: assert property (ce && a_out // R04
                                     |=> pin_oe[3:0] == 4'hf && pin_out[3:0] == $past(general_output[3:0]))
    else $error("group A output pins do not follow the register");

  a_output_drive_b: assert property (ce && b_out // R04
                                     |=> pin_oe[7:4] == 4'hf && pin_out[7:4] == $past(general_output[7:4]))
    else $error("group B output pins do not follow the register");

  a_input_read: assert property (ce && reg_rd && cfg_hit && mode == GPMUX_MODE_GPIO && !sel[3] // R05
                                 |=> reg_rvalid && reg_rdata[27:24] == $past(pin_sync[3:0]))
    else $error("group A input levels missing from the read value");

  a_mon_pins: assert property (ce && mode == GPMUX_MODE_MON // R06
                               |=> pin_oe == MON_OE && pin_out[PIN_MON_SCK] == $past(mon_sck))
    else $error("monitor pins not driven in monitor mode");

  a_mode_excl: assert property (ce && mode == GPMUX_MODE_GPIO |=> !mode_monitor || $past(reg_wr)) // R11
    else $error("monitor and general purpose functions active together");

  // Both synchronizer stages must have run out of reset, or a high trigger pin would look late.
  a_sync_delay: assert property (ce && $past(ce) && $past(ce, 2) && !$past(rst) && !$past(rst, 2) // R12
                                 && mode_monitor && $past(mode_monitor, 2)
                                 |-> monitor_trigger == $past(pin_in[PIN_MON_TRIG], 2))
    else $error("trigger input not delayed by exactly two stages");

  a_ds_invalid: assert property (ce && cfg_invalid |=> pin_oe == 8'h00 && !mod_clk_oe) // R10
    else $error("unlisted delta-sigma pattern still drives pins");

  a_ds_clock: assert property (ds_sample |-> mod_clk_out && mod_clk_oe && pin_oe == 8'h00) // R09
    else $error("sample strobe outside a driven modulator clock");

  c_gpio_entry: cover property (mode_monitor ##1 mode == GPMUX_MODE_GPIO);
  c_ds_sample: cover property (ds_sample);
  c_input_read: cover property (reg_rvalid && reg_rdata[31:24] != 8'h00);

endmodule // gpmux_pin_mux

// ---- verif/gpmux_pin_model.sv ----
// Far-side model: external pin levels with drive readback and a gated modulator clock.
`timescale 1ns/1ps
module gpmux_pin_model (
  input  wire logic       run,
  input  wire logic [7:0] ext,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_in,
  output logic            mod_clk
);
  // A pin that the device drives reads back its own level; every other pin shows the outside level.
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  // The modulator clock rests low between runs and starts off phase with the system clock.
  initial begin
    mod_clk = 1'b0;
    #7;
    forever begin
      #16;
      mod_clk = run ? ~mod_clk : 1'b0;
    end
  end
endmodule // gpmux_pin_model

// ---- verif/gpio_group_pin_mux_tb_top.sv ----
// Self-checking bench for the eight-pin group multiplexer.
`timescale 1ns/1ps
module gpio_group_pin_mux_tb_top import gpmux_pkg::*;;
  logic        clk, rst, ce, run, reg_wr, reg_rd, mon_cs_n, mon_sck, mon_mosi, mod_clk_in;
  logic        reg_rvalid, mon_miso, monitor_trigger, mod_clk_out, mod_clk_oe, ds_sample;
  logic        cfg_invalid, mode_monitor;
  logic [6:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0]  ext, pin_in, pin_out, pin_oe, ds_bits;
  int          err_count, n_checks;

  gpmux_pin_mux dut (.clk(clk), .rst(rst), .ce(ce), .mod_clk_in(mod_clk_in), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .mon_cs_n(mon_cs_n), .mon_sck(mon_sck), .mon_mosi(mon_mosi), .mon_miso(mon_miso),
    .monitor_trigger(monitor_trigger), .mod_clk_out(mod_clk_out), .mod_clk_oe(mod_clk_oe),
    .ds_bits(ds_bits), .ds_sample(ds_sample), .cfg_invalid(cfg_invalid), .mode_monitor(mode_monitor));
  gpmux_pin_model far (.run(run), .ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .mod_clk(mod_clk_in));

  // ----------------------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(32'(reg_rvalid), 32'h1);
    chk(reg_rdata, exp);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset;
    chk(32'({mode_monitor, pin_oe, pin_out}), 32'(17'h13800));
    rd(CFG_ADDR, 32'h0);
  endtask
  // A write elsewhere, and a write while the clock enable is low, must both leave the register alone.
  task automatic t_unmapped;
    wr(7'h7a, 32'h0000_0019);
    ce = 1'b0;
    cyc(1);
    wr(CFG_ADDR, 32'h0000_0019);
    ce = 1'b1;
    cyc(1);
    rd(7'h7a, 32'h0);
    cyc(1);
    rd(CFG_ADDR, 32'h0);
  endtask
  task automatic t_monitor;
    mon_cs_n = 1'b0;
    mon_sck = 1'b1;
    ext = 8'hc0;
    cyc(3);
    chk(32'({monitor_trigger, mon_miso, pin_out & MON_OE}), 32'h310);
    mon_cs_n = 1'b1;
    mon_sck = 1'b0;
    mon_mosi = 1'b1;
    ext = 8'h40;
    cyc(3);
    chk(32'({monitor_trigger, mon_miso, pin_out & MON_OE}), 32'h128);
  endtask
  task automatic t_gpio(input logic [6:0] sel);
    logic [7:0] oe;
    oe = {{4{sel[4]}}, {4{sel[3]}}};
    ext = 8'h3c;
    wr(CFG_ADDR, {16'hffa5, 9'h0, sel});
    cyc(3);
    chk(32'({mode_monitor, pin_oe}), 32'(oe));
    chk(32'(pin_out & oe), 32'(8'ha5 & oe));
    rd(CFG_ADDR, {ext & ~oe, 8'ha5, 9'h0, sel});
  endtask
  task automatic t_bad(input logic [6:0] sel, input logic inv);
    wr(CFG_ADDR, 32'(sel));
    cyc(2);
    chk(32'({cfg_invalid, pin_oe}), 32'({inv, 8'h00}));
  endtask
  task automatic t_ds_out;
    int   n;
    int   n_edge;
    logic prev_clk;
    n = 0;
    n_edge = 0;
    ext = 8'h5a;
    cyc(2);
    wr(CFG_ADDR, 32'h67);
    prev_clk = mod_clk_out;
    repeat (16) begin
      @(negedge clk);
      if (mod_clk_out !== prev_clk) n_edge++;
      prev_clk = mod_clk_out;
      if (ds_sample === 1'b1) begin
        n++;
        chk(32'({mod_clk_out, ds_bits}), 32'h15a);
      end
    end
    chk(n, 4);
    chk(n_edge, 16 / DS_HALF_CYCLES);
    chk(32'({mod_clk_oe, pin_oe}), 32'h100);
  endtask
  task automatic t_ds_in;
    ext = 8'h96;
    run = 1'b1;
    wr(CFG_ADDR, 32'h07);
    cyc(12);
    chk(32'({mod_clk_out, mod_clk_oe, ds_sample, ds_bits}), 32'h096);
    run = 1'b0;
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The modulator clock runs through reset so that the link side leaves reset cleanly.
  initial begin
    {rst, ce, run, mon_cs_n} = 4'hf;
    {reg_wr, reg_rd, mon_sck, mon_mosi} = 4'h0;
    reg_addr = 7'h00;
    reg_wdata = 32'h0;
    ext = 8'h00;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    run = 1'b0;
    t_reset;
    t_unmapped;
    t_monitor;
    t_gpio(7'h19);
    t_gpio(7'h01);
    t_gpio(7'h09);
    t_gpio(7'h11);
    t_bad(7'h27, 1'b1);
    t_bad(7'h03, 1'b0);
    t_bad(7'h47, 1'b1);
    t_ds_out;
    t_ds_in;
    close_out;
  end
  initial begin
    #100000;
    err_count++;
    close_out;
  end
endmodule // gpio_group_pin_mux_tb_top
